// File: core/plevel_pkg.sv
package plevel_pkg;

   // Level structure
   localparam int NLVL = 16;
   localparam int CTX_WORDS = 8;
   localparam logic [3:0] PROT_LVL = 4'hE;
   localparam logic [3:0] PAGE_LVL = 4'hF;
   localparam logic [2:0] LAST_WORD = 3'h7;

   // Register indices on the plain register port
   localparam logic [2:0] REG_DET = 3'h0;
   localparam logic [2:0] REG_ENA = 3'h1;
   localparam logic [2:0] REG_DSET = 3'h2;
   localparam logic [2:0] REG_DCLR = 3'h3;
   localparam logic [2:0] REG_STAT = 3'h4;

   // Reset values
   localparam logic [15:0] DET_RST = 16'h0000;
   localparam logic [15:0] ENA_RST = 16'h0000;

   // Status word field positions
   localparam int ST_CUR_LSB = 0;
   localparam int ST_SEL_LSB = 4;
   localparam int ST_RUNV_BIT = 8;
   localparam int ST_SELV_BIT = 9;
   localparam int ST_BUSY_BIT = 10;

   // Level pointer table base in memory
   localparam logic [15:0] PTR_BASE_DEF = 16'h0040;

   // Timing: one memory cycle and a whole level change
   localparam int CLK_NS = 4;
   localparam int MEM_CYCLE_NS = 1000;
   localparam int MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SWITCH_MEM_CYCLES = 38;
   localparam int SWITCH_CLKS_DEF = SWITCH_MEM_CYCLES * MEM_CYCLE_CLKS;
   localparam int TMR_W = 16;

   typedef enum logic [2:0] {
      SW_IDLE, SW_SV_PTR, SW_SV_WR, SW_LD_PTR, SW_LD_RD, SW_HOLD
   } sw_state_e;

   typedef logic [CTX_WORDS-1:0][15:0] ctx_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_s;

   typedef struct packed {
      logic [15:0] det;
      logic [15:0] ena;
      sw_state_e st;
      logic [3:0] cur;
      logic cur_vld;
      logic [3:0] tgt;
      logic tgt_vld;
      logic [2:0] wi;
      logic [15:0] base;
      logic [TMR_W-1:0] tmr;
      logic [15:0] rdata;
      mem_req_s mem;
      ctx_t img;
      logic ld_stb;
   } ctl_s;

endpackage

// File: core/level_sync.sv
`timescale 1ns/10ps
module level_sync #(
   parameter int W = 16
) (
   input wire logic core_clk, // Core clock
   input wire logic rst, // Synchronous reset
   input wire logic [W-1:0] d, // Asynchronous levels
   output logic [W-1:0] q // Synchronised levels
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   // Two stages; only the second stage is ever read
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end

   assign q = s2_r;

endmodule // level_sync

// File: core/priority_level_interrupt_switcher.sv
// Behaviour
// - Sixteen levels 0..15; higher number wins.
// - Every level can be requested by a pin or by program.
// - Internal processor conditions request certain levels.
// - Two 16-bit registers, detect and enable, one bit per level.
// - Some request lines fixed to bits; the rest free for customers.
// - Detect bits set by internal, external or program; held until cleared.
// - Hardware clears a detect bit once its request is serviced.
// - Give-up clears the running level's detect bit.
// - Only program writes change the enable register.
// - A level runs only while its enable bit is one.
// - Running level is highest with detect and enable both set.
// - Switch saves seven registers and status into old block.
// - Switch reloads seven registers and status from new block.
// - One pointer word per level gives its block address.
// - A block is eight consecutive words at the pointer.
// - A whole level change lasts 38 memory cycles.
// - Protection violation requests level fourteen.
// - Page fault or paging write fault requests level fifteen.
`timescale 1ns/10ps
module priority_level_interrupt_switcher
   import plevel_pkg::*;
#(
   parameter int SWITCH_CLKS = SWITCH_CLKS_DEF,
   parameter logic [15:0] PTR_BASE = PTR_BASE_DEF
) (
   input wire logic core_clk, // Core clock, 250 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic [2:0] reg_addr, // Register index
   input wire logic [15:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [15:0] reg_rdata, // Read data, cycle after strobe
   input wire logic [15:0] ext_req, // External request pins
   input wire logic prot_viol, // Protection violation pulse
   input wire logic page_fault, // Page or paging write fault pulse
   input wire logic instr_done, // Instruction boundary pulse
   input wire logic give_up, // Give-up-priority executed
   input wire logic srv_done, // Request serviced pulse
   input wire logic [3:0] srv_lvl, // Level that was serviced
   input wire ctx_t cpu_ctx, // Live CPU registers and status
   output ctx_t ctx_out, // Context loaded for new level
   output logic ctx_load, // Pulse: load ctx_out into CPU
   output logic cpu_hold, // CPU must stall while high
   output logic [3:0] run_level, // Running level
   output logic run_valid, // Some level is running
   output mem_req_s mem_o, // Memory request
   input wire logic mem_ack, // Memory access complete
   input wire logic [15:0] mem_rdata // Memory read data
);

   ctl_s q;
   ctl_s n;
   logic [15:0] ext_s;
   logic [15:0] set_v;
   logic [15:0] clr_v;
   logic [15:0] live;
   logic [3:0] sel;
   logic sel_vld;
   logic differs;

   // One-hot mask of a level
   function automatic logic [15:0] lvl_bit(input logic [3:0] l);
      lvl_bit = 16'h0001 << l;
   endfunction

   // Highest set bit; level 15 outranks all others
   function automatic logic [3:0] top_lvl(input logic [15:0] v);
      top_lvl = 4'h0;
      for (int i = 0; i < NLVL; i++) begin
         if (v[i]) begin
            top_lvl = 4'(i);
         end
      end
   endfunction

   // Request pins come from outside the clock domain
   level_sync #(.W(NLVL)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d(ext_req),
      .q(ext_s)
   );

   // Selection: both detect and enable must be set
   assign live = q.det & q.ena;
   assign sel = top_lvl(live);
   assign sel_vld = |live;
   assign differs = (sel_vld != q.cur_vld) || (sel_vld && sel != q.cur);

   // Set and clear sources of the detect register
   always_comb begin
      set_v = ext_s;
      clr_v = 16'h0000;
      if (prot_viol) begin
         set_v[PROT_LVL] = 1'b1;
      end
      if (page_fault) begin
         set_v[PAGE_LVL] = 1'b1;
      end
      if (reg_wr) begin
         case (reg_addr)
            REG_DET: begin
               set_v = set_v | reg_wdata;
               clr_v = clr_v | ~reg_wdata;
            end
            REG_DSET: begin
               set_v = set_v | reg_wdata;
            end
            REG_DCLR: begin
               clr_v = clr_v | reg_wdata;
            end
            default: begin
               clr_v = clr_v;
            end
         endcase
      end
      if (give_up && q.cur_vld) begin
         clr_v = clr_v | lvl_bit(q.cur);
      end
      if (srv_done) begin
         clr_v = clr_v | lvl_bit(srv_lvl);
      end
   end

   // Next state; a set always beats a clear in the same cycle
   always_comb begin
      n = q;
      n.ld_stb = 1'b0;
      n.rdata = 16'h0000;
      n.det = (q.det & ~clr_v) | set_v;
      if (reg_wr && reg_addr == REG_ENA) begin
         n.ena = reg_wdata;
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_DET: n.rdata = q.det;
            REG_ENA: n.rdata = q.ena;
            REG_STAT: begin
               n.rdata[ST_CUR_LSB +: 4] = q.cur;
               n.rdata[ST_SEL_LSB +: 4] = sel;
               n.rdata[ST_RUNV_BIT] = q.cur_vld;
               n.rdata[ST_SELV_BIT] = sel_vld;
               n.rdata[ST_BUSY_BIT] = (q.st != SW_IDLE);
            end
            default: n.rdata = 16'h0000;
         endcase
      end
      // Switch timer saturates so a slow memory cannot wrap it
      if (q.st != SW_IDLE && q.tmr != '1) begin
         n.tmr = q.tmr + 1'b1;
      end
      case (q.st)
         SW_IDLE: begin
            // Target is frozen here; later requests wait for next boundary
            if (instr_done && differs) begin
               n.tgt = sel;
               n.tgt_vld = sel_vld;
               n.img = cpu_ctx;
               n.tmr = '0;
               n.mem.req = 1'b1;
               n.mem.we = 1'b0;
               if (q.cur_vld) begin
                  n.st = SW_SV_PTR;
                  n.mem.addr = PTR_BASE + {12'h000, q.cur};
               end else begin
                  n.st = SW_LD_PTR;
                  n.mem.addr = PTR_BASE + {12'h000, sel};
               end
            end
         end
         SW_SV_PTR: begin
            if (mem_ack) begin
               n.base = mem_rdata;
               n.wi = 3'h0;
               n.st = SW_SV_WR;
               n.mem.we = 1'b1;
               n.mem.addr = mem_rdata;
               n.mem.wdata = q.img[0];
            end
         end
         SW_SV_WR: begin
            if (mem_ack) begin
               if (q.wi == LAST_WORD) begin
                  n.mem.we = 1'b0;
                  if (q.tgt_vld) begin
                     n.st = SW_LD_PTR;
                     n.mem.addr = PTR_BASE + {12'h000, q.tgt};
                  end else begin
                     n.st = SW_HOLD;
                     n.mem.req = 1'b0;
                  end
               end else begin
                  n.wi = q.wi + 3'h1;
                  n.mem.addr = q.base + {13'h0000, n.wi};
                  n.mem.wdata = q.img[n.wi];
               end
            end
         end
         SW_LD_PTR: begin
            if (mem_ack) begin
               n.base = mem_rdata;
               n.wi = 3'h0;
               n.st = SW_LD_RD;
               n.mem.addr = mem_rdata;
            end
         end
         SW_LD_RD: begin
            if (mem_ack) begin
               n.img[q.wi] = mem_rdata;
               if (q.wi == LAST_WORD) begin
                  n.st = SW_HOLD;
                  n.mem.req = 1'b0;
               end else begin
                  n.wi = q.wi + 3'h1;
                  n.mem.addr = q.base + {13'h0000, n.wi};
               end
            end
         end
         SW_HOLD: begin
            // Pad the change to its full length even on a fast memory
            if (q.tmr >= TMR_W'(SWITCH_CLKS - 1)) begin
               n.st = SW_IDLE;
               n.cur = q.tgt;
               n.cur_vld = q.tgt_vld;
               n.ld_stb = q.tgt_vld;
            end
         end
         default: begin
            n.st = SW_IDLE;
            n.mem.req = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
         q.det <= DET_RST;
         q.ena <= ENA_RST;
         q.st <= SW_IDLE;
      end else begin
         q <= n;
      end
   end

   // Outputs
   assign reg_rdata = q.rdata;
   assign ctx_out = q.img;
   assign ctx_load = q.ld_stb;
   assign cpu_hold = (q.st != SW_IDLE);
   assign run_level = q.cur;
   assign run_valid = q.cur_vld;
   assign mem_o = q.mem;

   // All checks sample on the core clock and rest while reset is high
   default clocking cb_core @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Switch finishes: busy then idle
   sequence s_fin;
      q.st != SW_IDLE ##1 q.st == SW_IDLE;
   endsequence

   // Save pointer fetched
   sequence s_sv_ptr;
      q.st == SW_SV_PTR && mem_ack;
   endsequence

   AST_ENA_PROG_ONLY: assert property (
      $changed(q.ena) |-> $past(reg_wr && reg_addr == REG_ENA))
      else $error("enable changed without a program write");

   AST_PROT_LVL: assert property (
      prot_viol |=> q.det[PROT_LVL])
      else $error("protection violation did not request its level");

   AST_PAGE_LVL: assert property (
      page_fault |=> q.det[PAGE_LVL])
      else $error("page fault did not request top level");

   AST_DET_HOLD: assert property (
      !(reg_wr || give_up || srv_done)
      |=> (q.det & $past(q.det)) == $past(q.det))
      else $error("detect bit dropped with no clear source");

   AST_GIVE_UP: assert property (
      (give_up && q.cur_vld && !reg_wr && !prot_viol && !page_fault
       && ext_s == 16'h0000) |=> !q.det[$past(q.cur)])
      else $error("give-up left running level requested");

   AST_BOUNDARY: assert property (
      (q.st == SW_IDLE && !(instr_done && differs)) |=> q.st == SW_IDLE)
      else $error("switch began away from a boundary");

   AST_START: assert property (
      (q.st == SW_IDLE && instr_done && differs)
      |=> q.st != SW_IDLE && q.tgt == $past(sel)
          && q.tgt_vld == $past(sel_vld))
      else $error("switch target is not the highest live level");

   AST_SAVE_FIRST: assert property (
      s_sv_ptr |=> q.mem.we && q.mem.wdata == q.img[0]
                   && q.mem.addr == $past(mem_rdata))
      else $error("save did not begin with word 0 at the block");

   AST_PTR_ADDR: assert property (
      q.st == SW_SV_PTR |-> q.mem.addr == PTR_BASE + {12'h000, q.cur})
      else $error("pointer fetched from wrong location");

   AST_BLOCK_ADDR: assert property (
      (q.st == SW_SV_WR || q.st == SW_LD_RD)
      |-> q.mem.addr == q.base + {13'h0000, q.wi})
      else $error("block word outside its eight words");

   AST_SWITCH_LEN: assert property (
      s_fin |-> $past(q.tmr) >= TMR_W'(SWITCH_CLKS - 1))
      else $error("level change shorter than its full length");

   AST_LOAD: assert property (
      ctx_load |-> $past(q.st) == SW_HOLD && run_valid && q.st == SW_IDLE)
      else $error("context load outside switch completion");

   AST_ENA_WRITE: assert property (
      (reg_wr && reg_addr == REG_ENA) |=> q.ena == $past(reg_wdata))
      else $error("enable write did not land");

   AST_SRV_CLEAR: assert property (
      (srv_done && !set_v[srv_lvl]) |=> !q.det[$past(srv_lvl)])
      else $error("serviced level still requested");

   AST_LOAD_WORD: assert property (
      (q.st == SW_LD_RD && mem_ack)
      |=> q.img[$past(q.wi)] == $past(mem_rdata))
      else $error("loaded word not kept in its slot");

   // Memory stays untouched between level changes
   AST_IDLE_QUIET: assert property (
      q.st == SW_IDLE |-> !q.mem.req)
      else $error("memory request outside a level change");

endmodule // priority_level_interrupt_switcher

// File: tb/mem_model.sv
`timescale 1ns/10ps
module mem_model
   import plevel_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic rst, // Synchronous reset
   input wire mem_req_s mem_o, // Request from switcher
   input wire logic [1:0] lat, // Wait cycles per access
   output logic mem_ack, // Access complete pulse
   output logic [15:0] mem_rdata // Read data with ack
);
   logic [15:0] mem [256];
   logic [1:0] wait_r;

   // One access per ack; data toggles outside acks so stale words never match
   always @(posedge core_clk) begin
      if (rst) begin
         mem_ack <= 1'b0;
         wait_r <= 2'h0;
         mem_rdata <= 16'h0000;
      end else if (mem_o.req && !mem_ack && wait_r == lat) begin
         mem_ack <= 1'b1;
         wait_r <= 2'h0;
         if (mem_o.we)
            mem[mem_o.addr[7:0]] <= mem_o.wdata;
         mem_rdata <= mem_o.we ? ~mem_rdata : mem[mem_o.addr[7:0]];
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_o.req && !mem_ack)
            wait_r <= wait_r + 2'h1;
      end
   end
endmodule // mem_model

// File: tb/tb_priority_level_interrupt_switcher.sv
`timescale 1ns/10ps
module tb_priority_level_interrupt_switcher
   import plevel_pkg::*;
();
   localparam int SWC = 60;
   logic core_clk, rst, reg_wr, reg_rd, prot_viol, page_fault, ld;
   logic instr_done, give_up, srv_done, mem_ack, ctx_load, cpu_hold;
   logic run_valid;
   logic [2:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, ext_req, mem_rdata, v, e;
   logic [3:0] srv_lvl, run_level, lv, nl;
   logic [1:0] lat;
   ctx_t cpu_ctx, ctx_out;
   mem_req_s mem_o;
   logic [15:0] img [16][8];
   int err_total, checks, cyc, seed, n;

   priority_level_interrupt_switcher #(.SWITCH_CLKS(SWC)) dut (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_req(ext_req), .prot_viol(prot_viol),
      .page_fault(page_fault), .instr_done(instr_done),
      .give_up(give_up), .srv_done(srv_done), .srv_lvl(srv_lvl),
      .cpu_ctx(cpu_ctx), .ctx_out(ctx_out), .ctx_load(ctx_load),
      .cpu_hold(cpu_hold), .run_level(run_level), .run_valid(run_valid),
      .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   mem_model mem_m (.core_clk(core_clk), .rst(rst), .mem_o(mem_o),
      .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   // Clock at 250 MHz
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         conclude();
      end
   end

   function automatic int blk(logic [3:0] l, int i);
      return 16'h0080 + l * 8 + i;
   endfunction

   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Strobe then one idle cycle, so no strobe is assigned twice at one edge
   task automatic wr(logic [2:0] a, logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(logic [2:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      v = reg_rdata;
      @(posedge core_clk);
   endtask

   // Boundary pulse, wait out the switch, then check save and load images
   task automatic sw(logic [3:0] l, logic vld);
      logic [3:0] old;
      logic ov;
      old = run_level;
      ov = run_valid;
      for (int i = 0; i < 8; i++)
         cpu_ctx[i] <= 16'($random(seed));
      lat <= 2'($random(seed));
      instr_done <= 1'b1;
      @(posedge core_clk);
      instr_done <= 1'b0;
      n = 0;
      ld = 1'b0;
      do begin
         @(negedge core_clk);
         n++;
         if (ctx_load === 1'b1)
            ld = 1'b1;
      end while (cpu_hold === 1'b1 && n < 3000);
      chk("length", {15'h0, n >= SWC}, 16'h0001);
      chk("run_valid", {15'h0, run_valid}, {15'h0, vld});
      chk("ctx_load", {15'h0, ld}, {15'h0, vld});
      if (vld)
         chk("run_level", {12'h0, run_level}, {12'h0, l});
      for (int i = 0; i < 8; i++) begin
         if (ov) begin
            chk("saved", mem_m.mem[blk(old, i)], cpu_ctx[i]);
            img[old][i] = cpu_ctx[i];
         end
         if (vld)
            chk("loaded", ctx_out[i], img[l][i]);
      end
      @(posedge core_clk);
   endtask

   // Main sequence
   initial begin
      seed = 32'h38a9;
      {reg_wr, reg_rd, prot_viol, page_fault, instr_done} = 5'h00;
      {give_up, srv_done, srv_lvl, reg_addr} = 9'h000;
      reg_wdata = 16'h0000;
      ext_req = 16'h0000;
      lat = 2'h0;
      cpu_ctx = '0;
      rst = 1'b1;
      for (int l = 0; l < 16; l++) begin
         mem_m.mem[8'h40 + l] = 16'(blk(4'(l), 0));
         for (int i = 0; i < 8; i++) begin
            img[l][i] = {4'hA, 4'(l), 5'h00, 3'(i)};
            mem_m.mem[blk(4'(l), i)] = img[l][i];
         end
      end
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(REG_DET);
      chk("det_rst", v, DET_RST);
      rd(REG_ENA);
      chk("ena_rst", v, ENA_RST);
      e = 16'($random(seed));
      wr(REG_ENA, e);
      rd(REG_ENA);
      chk("ena_rw", v, e);
      wr(REG_ENA, 16'h0000);
      wr(REG_STAT, 16'hFFFF);
      rd(REG_STAT);
      chk("stat_ro", v, 16'h0000);
      wr(3'h5, 16'hFFFF);
      rd(3'h5);
      chk("unmapped", v, 16'h0000);
      wr(REG_DSET, 16'h00F0);
      wr(REG_DCLR, 16'h0030);
      rd(REG_DET);
      chk("set_clr", v, 16'h00C0);
      wr(REG_DET, 16'h0000);
      wr(REG_ENA, 16'hFFFF);
      lv = 4'h0;
      for (int k = 0; k < 8; k++) begin
         nl = 4'($unsigned($random(seed)) % 13);
         if (nl == lv)
            nl = nl + 4'h1;
         wr(REG_DET, 16'h0000);
         if (k % 2 == 1) begin
            wr(REG_DSET, 16'h0001 << nl);
         end else begin
            ext_req[nl] <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_req <= 16'h0000;
            repeat (3) @(posedge core_clk);
            rd(REG_DET);
            chk("pin_set", v, 16'h0001 << nl);
         end
         sw(nl, 1'b1);
         lv = nl;
      end
      // Pin and program raise the running level together: still one bit
      ext_req[lv] <= 1'b1;
      wr(REG_DSET, 16'h0001 << lv);
      ext_req <= 16'h0000;
      repeat (3) @(posedge core_clk);
      rd(REG_DET);
      chk("shared", v, 16'h0001 << lv);
      // Status shows running and selected level, switcher not busy
      e = 16'h0000;
      e[ST_CUR_LSB +: 4] = lv;
      e[ST_SEL_LSB +: 4] = lv;
      e[ST_RUNV_BIT] = 1'b1;
      e[ST_SELV_BIT] = 1'b1;
      rd(REG_STAT);
      chk("status", v, e);
      // Internal conditions preempt, then control falls back level by level
      prot_viol <= 1'b1;
      @(posedge core_clk);
      prot_viol <= 1'b0;
      repeat (2) @(posedge core_clk);
      sw(PROT_LVL, 1'b1);
      page_fault <= 1'b1;
      @(posedge core_clk);
      page_fault <= 1'b0;
      repeat (2) @(posedge core_clk);
      sw(PAGE_LVL, 1'b1);
      give_up <= 1'b1;
      @(posedge core_clk);
      give_up <= 1'b0;
      repeat (2) @(posedge core_clk);
      sw(PROT_LVL, 1'b1);
      srv_lvl <= PROT_LVL;
      srv_done <= 1'b1;
      @(posedge core_clk);
      srv_done <= 1'b0;
      rd(REG_DET);
      chk("srv_clear", v, 16'h0001 << lv);
      sw(lv, 1'b1);
      wr(REG_ENA, ~(16'h0001 << lv));
      sw(lv, 1'b0);
      rd(REG_ENA);
      chk("ena_kept", v, ~(16'h0001 << lv));
      rd(REG_DET);
      chk("det_kept", v, 16'h0001 << lv);
      wr(REG_ENA, 16'hFFFF);
      sw(lv, 1'b1);
      conclude();
   end
endmodule // tb_priority_level_interrupt_switcher
